// file: verilog/bpf_defs.vh
/*
 bpf_defs.vh: constants for the broadcast packet filter, i.e. command
 codes, payload byte offsets, settings bit positions, classifier values.
 Assumes byte offsets count from the first byte of each frame.
*/
`ifndef BPF_DEFS_VH
`define BPF_DEFS_VH
`define BPF_CMD_ENABLE 8'h10
`define BPF_RSP_ENABLE 8'h90
`define BPF_CMD_DISABLE 8'h11
`define BPF_HDR_TYPE_BYTE 6'h04
`define BPF_SET_FIRST_BYTE 6'h10
`define BPF_SET_LAST_BYTE 6'h13
`define BPF_CKS_FIRST_BYTE 6'h14
`define BPF_CKS_LAST_BYTE 6'h17
`define BPF_PAD_LAST_BYTE 6'h2D
`define BPF_BIT_ARP 0
`define BPF_BIT_DHCP_CLIENT 1
`define BPF_BIT_DHCP_SERVER 2
`define BPF_BIT_NETBIOS 3
`define BPF_CLASS_MASK 4'hF
`define BPF_SETTINGS_RESET 32'h0000_0000
`define BPF_ETYPE_ARP 16'h0806
`define BPF_ETYPE_IPV4 16'h0800
`define BPF_IPPROTO_UDP 8'h11
`define BPF_PORT_DHCP_CLIENT 16'h0044
`define BPF_PORT_DHCP_SERVER 16'h0043
`define BPF_PORT_NB_NAME 16'h0089
`define BPF_PORT_NB_DGRAM 16'h008A
`define BPF_OFS_ETYPE_HI 6'h0C
`define BPF_OFS_ETYPE_LO 6'h0D
`define BPF_OFS_IHL 6'h0E
`define BPF_OFS_IPPROTO 6'h17
`endif

// file: verilog/bpf_classifier.v
/*
 bpf_classifier.v: classifies one received frame streamed a byte at a
 time into broadcast protocol classes.
 Assumes a start pulse on the first byte and bytes valid when flagged.
*/
`timescale 1ns/10ps
`include "bpf_defs.vh"

module bpf_classifier (
  input wire ref_clk,
  input wire reset,
  input wire rx_start,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  output wire is_bcast,
  output wire [3:0] class_hits
);
  reg [10:0] pos;
  reg [5:0] dst_ff;
  reg [15:0] etype;
  reg [5:0] ihl_bytes;
  reg [7:0] ipproto;
  reg [7:0] port_hi;
  reg [15:0] udp_dport;
  wire [10:0] cur;
  wire [10:0] dport_at;
  wire ipv4_udp;

  // byte index restarts at the frame start
  assign cur = rx_start ? 11'h000 : pos;
  // udp destination port sits after the variable length ip header
  assign dport_at = 11'h00E + {5'h00, ihl_bytes} + 11'h002;

  // capture header fields as their bytes pass
  always @(posedge ref_clk) begin
    if (reset) begin
      pos <= 11'h000;
      dst_ff <= 6'h00;
      etype <= 16'h0000;
      ihl_bytes <= 6'h14;
      ipproto <= 8'h00;
      port_hi <= 8'h00;
      udp_dport <= 16'h0000;
    end else begin
      if (rx_start) begin
        dst_ff <= 6'h00;
        etype <= 16'h0000;
        ipproto <= 8'h00;
        udp_dport <= 16'h0000;
      end
      if (rx_valid) begin
        // test cur, not pos, so a start still restarts after saturation
        if (cur != 11'h7FF)
          pos <= cur + 11'h001; // saturate on jumbo frames
        if (cur < 11'h006)
          dst_ff[cur[2:0]] <= (rx_byte == 8'hFF);
        if (cur == {5'h00, `BPF_OFS_ETYPE_HI})
          etype[15:8] <= rx_byte;
        if (cur == {5'h00, `BPF_OFS_ETYPE_LO})
          etype[7:0] <= rx_byte;
        if (cur == {5'h00, `BPF_OFS_IHL})
          ihl_bytes <= {rx_byte[3:0], 2'b00};
        if (cur == {5'h00, `BPF_OFS_IPPROTO})
          ipproto <= rx_byte;
        if (cur == dport_at)
          port_hi <= rx_byte;
        if (cur == dport_at + 11'h001)
          udp_dport <= {port_hi, rx_byte};
      end
    end
  end

  assign is_bcast = &dst_ff;
  assign ipv4_udp = is_bcast && (etype == `BPF_ETYPE_IPV4) &&
                    (ipproto == `BPF_IPPROTO_UDP);
  // class decode, valid once the udp port has passed
  assign class_hits[`BPF_BIT_ARP] = is_bcast &&
                                    (etype == `BPF_ETYPE_ARP);
  assign class_hits[`BPF_BIT_DHCP_CLIENT] = ipv4_udp &&
    (udp_dport == `BPF_PORT_DHCP_CLIENT);
  assign class_hits[`BPF_BIT_DHCP_SERVER] = ipv4_udp &&
    (udp_dport == `BPF_PORT_DHCP_SERVER);
  assign class_hits[`BPF_BIT_NETBIOS] = ipv4_udp &&
    ((udp_dport == `BPF_PORT_NB_NAME) ||
     (udp_dport == `BPF_PORT_NB_DGRAM));
endmodule

// file: verilog/bpf_filter.v
/*
 bpf_filter.v: receive-side broadcast frame filter. Parses the enable
 and disable commands from a byte stream, holds the settings word and
 gives a forward or drop verdict at the end of each received frame.
 Assumes the command stream has passed checksum and identifier checks
 upstream, and that both streams are synchronous to ref_clk.
*/
`timescale 1ns/10ps
`include "bpf_defs.vh"

// How it works
// - enable command 0x10 turns on filtering with its settings word
// - with no class enabled every broadcast frame is dropped
// - settings word is bytes 16..19, checksum 20..23, pad to 45
// - settings bit one forwards its class, zero drops it
// - bit 0: broadcast destination with ethertype 0x0806 is arp
// - arp classification and its control are always present
// - bit 1: ipv4 udp broadcast to port 68 is dhcp client
// - bit 2: ipv4 udp broadcast to port 67 is dhcp server
// - bit 3: ipv4 udp broadcast to port 137 or 138 is netbios
// - unsupported optional classes are blocked while filtering
// - supported classes are reported as a capabilities field
// - enable command accepted if it carries bytes 16..19, answered with code 0x90
module bpf_filter #(
  parameter [3:0] SUPPORTED = 4'hF
) (
  input wire ref_clk,
  input wire reset,
  input wire cmd_start,
  input wire cmd_valid,
  input wire [7:0] cmd_byte,
  input wire cmd_end,
  input wire rx_start,
  input wire rx_valid,
  input wire [7:0] rx_byte,
  input wire rx_end,
  output reg rsp_valid,
  output reg [7:0] rsp_code,
  output reg filter_active,
  output reg [31:0] filter_settings,
  output reg [3:0] bcast_caps,
  output reg verdict_valid,
  output reg verdict_forward,
  output reg verdict_bcast,
  output reg [3:0] verdict_class
);
  localparam ST_IDLE = 2'b00;
  localparam ST_BODY = 2'b01;
  localparam ST_SKIP = 2'b10;

  reg [1:0] state;
  reg [5:0] cmd_pos;
  reg [7:0] cmd_type;
  reg [31:0] shadow;
  reg [1:0] next_state;
  reg [3:0] next_fwd_mask;
  wire [3:0] eff_caps;
  wire [3:0] hits;
  wire is_bcast;
  wire [5:0] cur_pos;
  wire forward_now;

  // arp support can never be dropped from the capability set
  assign eff_caps = SUPPORTED | 4'h1;
  assign cur_pos = cmd_start ? 6'h00 : cmd_pos;

  // position mask applied to the settings word
  function [3:0] class_mask;
    input [31:0] word;
    input [3:0] caps;
    begin
      // reserved bits never reach the decode
      class_mask = word[3:0] & `BPF_CLASS_MASK & caps;
    end
  endfunction

  bpf_classifier u_cls (
    .ref_clk(ref_clk),
    .reset(reset),
    .rx_start(rx_start),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte),
    .is_bcast(is_bcast),
    .class_hits(hits)
  );

  // command parser next state
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (cmd_start && cmd_valid)
          next_state = ST_BODY;
      end
      ST_BODY: begin
        if (cmd_end)
          next_state = ST_IDLE;
        else if (cmd_valid && cur_pos > `BPF_PAD_LAST_BYTE)
          next_state = ST_SKIP; // overlong frame, ignore the rest
      end
      ST_SKIP: begin
        if (cmd_end)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (cmd_start && cmd_valid)
      next_state = ST_BODY;
  end

  // collect type byte and settings word from the command frame
  always @(posedge ref_clk) begin
    if (reset) begin
      state <= ST_IDLE;
      cmd_pos <= 6'h00;
      cmd_type <= 8'h00;
      shadow <= `BPF_SETTINGS_RESET;
    end else begin
      state <= next_state;
      if (cmd_valid && (cmd_start || state == ST_BODY)) begin
        if (cur_pos != 6'h3F)
          cmd_pos <= cur_pos + 6'h01;
        if (cur_pos == `BPF_HDR_TYPE_BYTE)
          cmd_type <= cmd_byte;
        // settings word, most significant byte first
        if (cur_pos >= `BPF_SET_FIRST_BYTE &&
            cur_pos <= `BPF_SET_LAST_BYTE)
          shadow <= {shadow[23:0], cmd_byte};
      end
    end
  end

  // apply the command at frame end and answer it
  always @(posedge ref_clk) begin
    if (reset) begin
      filter_active <= 1'b0;
      filter_settings <= `BPF_SETTINGS_RESET;
      rsp_valid <= 1'b0;
      rsp_code <= 8'h00;
      bcast_caps <= 4'h0;
    end else begin
      rsp_valid <= 1'b0;
      bcast_caps <= eff_caps;
      // short frames lacking the settings word are not applied
      // an overlong frame is still applied, only its extra bytes dropped
      if (cmd_end && (state == ST_BODY || state == ST_SKIP) &&
          cmd_pos > `BPF_SET_LAST_BYTE) begin
        if (cmd_type == `BPF_CMD_ENABLE) begin
          filter_active <= 1'b1;
          filter_settings <= shadow;
          rsp_valid <= 1'b1;
          rsp_code <= `BPF_RSP_ENABLE;
        end else if (cmd_type == `BPF_CMD_DISABLE) begin
          filter_active <= 1'b0;
          rsp_valid <= 1'b1;
          rsp_code <= cmd_type | 8'h80;
        end
      end
    end
  end

  // per-class forwarding mask from the stored word
  always @* begin
    next_fwd_mask = class_mask(filter_settings, eff_caps);
  end

  // non-broadcast frames and an inactive filter always pass
  assign forward_now = !is_bcast || !filter_active ||
                       ((hits & next_fwd_mask) != 4'h0);

  // verdict at frame end, one cycle pulse
  always @(posedge ref_clk) begin
    if (reset) begin
      verdict_valid <= 1'b0;
      verdict_forward <= 1'b0;
      verdict_bcast <= 1'b0;
      verdict_class <= 4'h0;
    end else begin
      verdict_valid <= rx_end;
      if (rx_end) begin
        verdict_forward <= forward_now;
        verdict_bcast <= is_bcast;
        verdict_class <= hits;
      end
    end
  end
endmodule

// file: testbench/bpf_checker.sv
/* bpf_checker.sv: port assertions for the broadcast filter.
 Assumes one clock domain with a synchronous active high reset. */
`timescale 1ns/10ps
module bpf_checker #(
  parameter [3:0] SUPPORTED = 4'hF
) (
  input wire ref_clk,
  input wire reset,
  input wire cmd_end,
  input wire rx_end,
  input wire rsp_valid,
  input wire [7:0] rsp_code,
  input wire filter_active,
  input wire [31:0] filter_settings,
  input wire [3:0] bcast_caps,
  input wire verdict_valid,
  input wire verdict_forward,
  input wire verdict_bcast,
  input wire [3:0] verdict_class
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  // arp support is forced on whatever the parameter says
  wire [3:0] caps = SUPPORTED | 4'h1;

  enable_answer_a: assert property ($rose(filter_active) |-> rsp_valid
    && rsp_code == 8'h90) else $error("filter on without enable answer");
  answer_cause_a: assert property (rsp_valid |-> $past(cmd_end))
    else $error("response without command end");
  verdict_time_a: assert property (rx_end |=> verdict_valid)
    else $error("verdict missing after frame end");
  class_gate_a: assert property (verdict_valid && verdict_bcast
    && filter_active |-> verdict_forward ==
    |(verdict_class & filter_settings[3:0] & caps)) else $error("bad gate");
  none_drop_a: assert property (verdict_valid && verdict_bcast
    && filter_active && filter_settings[3:0] == 4'h0 |-> !verdict_forward)
    else $error("broadcast passed with no class on");
  open_pass_a: assert property (verdict_valid && !(verdict_bcast
    && filter_active) |-> verdict_forward) else $error("frame dropped");
  caps_value_a: assert property (!$past(reset) |-> bcast_caps == caps)
    else $error("capabilities field wrong");
  class_shape_a: assert property (verdict_valid && |verdict_class
    |-> verdict_bcast && !(verdict_class[0] && |verdict_class[3:1]))
    else $error("class hit on wrong frame");
endmodule
bind bpf_filter bpf_checker #(.SUPPORTED(SUPPORTED)) i_chk (.*);

// file: testbench/bpf_mc_model.sv
/* bpf_mc_model.sv: management controller sending command frames.
 Assumes send is called just after a falling edge of ref_clk. */
`timescale 1ns/10ps
module bpf_mc_model (
  input wire ref_clk,
  output reg cmd_start,
  output reg cmd_valid,
  output reg [7:0] cmd_byte,
  output reg cmd_end
);
  // bus idle at time zero
  initial begin
    cmd_start = 1'b0;
    cmd_valid = 1'b0;
    cmd_byte = 8'h00;
    cmd_end = 1'b0;
  end
  // one whole frame; released byte inverted so stale data never matches
  task send(input [7:0] typ, input [31:0] set, input integer len);
    integer i;
    begin
      for (i = 0; i < len; i = i + 1) begin
        cmd_start = (i == 0);
        cmd_valid = 1'b1;
        cmd_byte = (i == 4) ? typ : (i > 15 && i < 20) ?
          set[8 * (19 - i) +: 8] : 8'h00;
        @(negedge ref_clk);
      end
      cmd_start = 1'b0;
      cmd_valid = 1'b0;
      cmd_byte = ~cmd_byte;
      cmd_end = 1'b1;
      @(negedge ref_clk);
      cmd_end = 1'b0;
    end
  endtask
endmodule

// file: testbench/broadcast_packet_filter_tb.sv
/* broadcast_packet_filter_tb.sv: self-checking bench for bpf_filter.
 Assumes a filter built with only the dhcp client class optional. */
`timescale 1ns/10ps
module broadcast_packet_filter_tb;
  reg ref_clk = 1'b0;
  reg reset = 1'b1;
  reg rx_start = 1'b0;
  reg rx_valid = 1'b0;
  reg rx_end = 1'b0;
  reg [7:0] rx_byte = 8'h00;
  wire cmd_start, cmd_valid, cmd_end, rsp_valid, filter_active;
  wire verdict_valid, verdict_forward, verdict_bcast;
  wire [7:0] cmd_byte, rsp_code;
  wire [31:0] filter_settings;
  wire [3:0] bcast_caps, verdict_class;
  integer n_errors = 0;
  integer comparisons = 0;

  bpf_filter #(.SUPPORTED(4'h2)) i_dut (.*);
  bpf_mc_model i_mc (.*);
  // 20 MHz
  always #25 ref_clk = ~ref_clk;

  task close_out;
    begin
      if (n_errors == 0 && comparisons > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // command, then a bounded wait for its answer
  task cmd(input [7:0] typ, input [31:0] set, input integer len, input e);
    integer n;
    begin
      i_mc.send(typ, set, len);
      n = 0;
      while (rsp_valid !== 1'b1 && n < 3) begin
        @(negedge ref_clk);
        n = n + 1;
      end
      chk(rsp_valid, e);
      if (e)
        chk(rsp_code, typ | 8'h80);
    end
  endtask
  // ipv4 header of five words, so the udp port sits at bytes 36 and 37
  function [7:0] fb(input integer i, input bc, input [15:0] et,
                    input [15:0] pt);
    case (i)
      12: fb = et[15:8];
      13: fb = et[7:0];
      14: fb = 8'h45;
      23: fb = 8'h11;
      36: fb = pt[15:8];
      37: fb = pt[7:0];
      default: fb = (i < 6 && bc) ? 8'hFF : 8'h00;
    endcase
  endfunction
  task rx(input bc, input [15:0] et, input [15:0] pt, input e);
    integer i;
    reg [3:0] ec;
    begin
      // expected class hits, independent of settings and support
      ec[0] = bc && et == 16'h0806;
      ec[1] = bc && et == 16'h0800 && pt == 16'h0044;
      ec[2] = bc && et == 16'h0800 && pt == 16'h0043;
      ec[3] = bc && et == 16'h0800 &&
              (pt == 16'h0089 || pt == 16'h008A);
      for (i = 0; i < 38; i = i + 1) begin
        rx_start = (i == 0);
        rx_valid = 1'b1;
        rx_byte = fb(i, bc, et, pt);
        @(negedge ref_clk);
      end
      rx_start = 1'b0;
      rx_valid = 1'b0;
      rx_byte = ~rx_byte;
      rx_end = 1'b1;
      @(negedge ref_clk);
      rx_end = 1'b0;
      i = 0;
      while (verdict_valid !== 1'b1 && i < 3) begin
        @(negedge ref_clk);
        i = i + 1;
      end
      chk(verdict_valid, 1);
      chk(verdict_forward, e);
      chk(verdict_bcast, bc);
      chk(verdict_class, ec);
    end
  endtask

  // main sequence
  initial begin
    repeat (6) @(negedge ref_clk);
    reset = 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(bcast_caps, 4'h3);
    chk(filter_active, 0);
    rx(1, 16'h0806, 0, 1);
    cmd(8'h10, 0, 46, 1);
    rx(1, 16'h0806, 0, 0);
    rx(0, 16'h0800, 16'h0043, 1);
    cmd(8'h10, 32'hFFFFFFFF, 46, 1);
    chk(filter_settings, 32'hFFFFFFFF);
    rx(1, 16'h0806, 0, 1);
    rx(1, 16'h0800, 16'h0044, 1);
    rx(1, 16'h0800, 16'h0043, 0);
    rx(1, 16'h0800, 16'h0089, 0);
    rx(1, 16'h0800, 16'h008A, 0);
    cmd(8'h10, 32'h12345602, 48, 1);
    rx(1, 16'h0806, 0, 0);
    rx(1, 16'h0800, 16'h0044, 1);
    rx(1, 16'h0800, 16'h0045, 0);
    cmd(8'h10, 1, 19, 0);
    cmd(8'h0E, 1, 46, 0);
    chk(filter_settings, 32'h12345602);
    cmd(8'h11, 0, 46, 1);
    rx(1, 16'h0806, 0, 1);
    close_out;
  end
  // hang guard, well past the roughly 740 cycles the run needs
  initial begin
    #(50 * 8000);
    n_errors = n_errors + 1;
    close_out;
  end
endmodule
